// ### design/rtce_defines.svh
// Constants for the real time clock event, alarm and power control block.
// Overview of operation
// - Each alarm holds any clock or calendar value and fires when the time matches while on main supply.
// - Each alarm keeps its own status flag readable by the host.
// - When enabled, an alarm pulls the active-low open-drain interrupt output low.
// - Repeat mode gives periodic interrupts, rate chosen by which fields are compared.
// - Backup supply below 85 percent sets warning one, below 75 percent warning two.
// - Supply-low output is driven while main supply is below one of six trip levels.
// - A high level on the event input is a detected event.
// - A control bit enables detection; when disabled the event input is gated off.
// - A second control bit keeps event detection working on backup supply.
// - With detection on, event output goes low on an event until the flag clears.
// - Every event captures time and date; the first capture is kept until cleared.
// - Time stamps of the last three events roll and are read by index.
// - Host selects one of seven output frequencies or off for the frequency pin.
// - The 50 or 60 Hz line input is the primary timebase.
// - With no line input the crystal oscillator input is the timebase.
// - Calendar is correct through 2099 with leap year and daylight saving correction.
// - Switch to backup only when main is below backup minus hysteresis and below trip.
// - The serial interface is disabled while running from the backup supply unless serial-on-backup is enabled.
// - On backup the serial bus stays off until serial-on-backup is enabled.
// - Repeat mode pulls the interrupt low for 250 ms per match and sets the flag.
`ifndef RTCE_DEFINES_SVH
`define RTCE_DEFINES_SVH
`define RTCE_CORE_CLK_HZ    64'd25000000
`define RTCE_IRQ_PULSE_MS   64'd250
`define RTCE_IRQ_PULSE_CYC  ((`RTCE_IRQ_PULSE_MS * `RTCE_CORE_CLK_HZ) / 64'd1000)
`define RTCE_OSC_PER_SEC    16'd32768
`define RTCE_LINE50_PER_SEC 16'd50
`define RTCE_LINE60_PER_SEC 16'd60
`define RTCE_TRIP_LEVELS    3'd6
`define RTCE_TS_W           33
`define RTCE_DST_HOUR       5'h02
`define RTCE_FQ_1HZ_BIT     14
`define RTCE_FQ_2HZ_BIT     13
`define RTCE_FQ_4HZ_BIT     12
`define RTCE_FQ_8HZ_BIT     11
`define RTCE_FQ_64HZ_BIT    8
`define RTCE_FQ_1KHZ_BIT    4
`endif

// ### design/rtce_pkg.sv
// Types shared by the real time clock event, alarm and power control block.
package rtce_pkg;
    typedef enum logic [2:0] {
        rtce_fq_off   = 3'h0,
        rtce_fq_1hz   = 3'h1,
        rtce_fq_2hz   = 3'h2,
        rtce_fq_4hz   = 3'h3,
        rtce_fq_8hz   = 3'h4,
        rtce_fq_64hz  = 3'h5,
        rtce_fq_1khz  = 3'h6,
        rtce_fq_32khz = 3'h7
    } rtce_freq_type;
    typedef enum logic [0:0] {
        rtce_lk_idle = 1'b0,
        rtce_lk_wait = 1'b1
    } rtce_link_state_type;
endpackage

// ### design/rtce_ctrl.sv
// Alarm, event stamping, power switchover, timebase and calendar logic of the clock.
`timescale 1ns/1ns
`default_nettype none
`include "rtce_defines.svh"
module rtce_ctrl #(
    parameter longint IRQ_PULSE_CYC = longint'(`RTCE_IRQ_PULSE_CYC),
    parameter int     TS_DEPTH      = 3
) (
    // Clocks and reset.
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  link_clk,
    // Analog comparator and timebase pins.
    input  wire logic                  main_below_trip,
    input  wire logic                  main_below_backup_hys,
    input  wire logic                  bat_below_85,
    input  wire logic                  bat_below_75,
    input  wire logic                  line_in,
    input  wire logic                  line_present,
    input  wire logic                  line_is_60hz,
    input  wire logic                  osc_in,
    input  wire logic                  event_in,
    // Configuration bits.
    input  wire logic [2:0]            trip_sel,
    input  wire logic                  serial_on_backup_en,
    input  wire logic                  event_det_en,
    input  wire logic                  event_on_backup_en,
    input  wire logic [2:0]            freq_sel,
    input  wire logic                  dst_en,
    input  wire logic [3:0]            dst_fwd_month,
    input  wire logic [4:0]            dst_fwd_date,
    input  wire logic [3:0]            dst_bwd_month,
    input  wire logic [4:0]            dst_bwd_date,
    // Time load, as fields sec, min, hour, date, month, year.
    input  wire logic                  time_load,
    input  wire logic [`RTCE_TS_W-1:0] time_load_val,
    // Alarm setup per alarm.
    input  wire logic [1:0]            alarm_en,
    input  wire logic [1:0]            alarm_irq_en,
    input  wire logic [1:0]            alarm_repeat,
    input  wire logic [11:0]           alarm_field_en,
    input  wire logic [2*`RTCE_TS_W-1:0] alarm_val,
    input  wire logic [1:0]            alarm_clr,
    input  wire logic                  ts_first_clr,
    // Host link, on link_clk.
    input  wire logic                  ts_rd_req,
    input  wire logic [1:0]            ts_rd_index,
    input  wire logic                  event_clr_req,
    output logic [`RTCE_TS_W-1:0]      ts_rd_data,
    output logic                       ts_rd_valid,
    // Status and pins.
    output logic [`RTCE_TS_W-1:0]      time_now,
    output logic [1:0]                 alarm_status,
    output logic                       event_flag,
    output logic                       first_ts_valid,
    output logic                       bat_warn1,
    output logic                       bat_warn2,
    output logic                       on_backup,
    output logic                       serial_active,
    output logic                       use_line,
    output logic [2:0]                 trip_level,
    output logic                       irq_oe,
    output logic                       supply_low_oe,
    output logic                       event_detect_oe,
    output logic                       freq_out,
    output logic                       osc_out
);
    localparam int W = `RTCE_TS_W;
    initial begin
        if (IRQ_PULSE_CYC < 1 || TS_DEPTH != 3)
            $error("rtce_ctrl: unsupported parameter values.");
    end

    // Two-flop synchronisers for every asynchronous pin except line_is_60hz.
    localparam int NS = 8;
    logic [NS-1:0] pin_meta;
    logic [NS-1:0] pin_sync;
    always_ff @(posedge core_clk) begin
        pin_meta <= {main_below_trip, main_below_backup_hys, bat_below_85, bat_below_75,
                     line_in, line_present, osc_in, event_in};
        pin_sync <= pin_meta;
    end
    wire s_trip = pin_sync[7];
    wire s_hys  = pin_sync[6];
    wire s_b85  = pin_sync[5];
    wire s_b75  = pin_sync[4];
    wire s_line = pin_sync[3];
    wire s_lpr  = pin_sync[2];
    wire s_osc  = pin_sync[1];
    wire s_evt  = pin_sync[0];

    // Power switchover and supply monitors; leaving backup needs only one condition false.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            on_backup     <= 1'b0;
            supply_low_oe <= 1'b0;
            bat_warn1     <= 1'b0;
            bat_warn2     <= 1'b0;
            serial_active <= 1'b1;
            trip_level    <= 3'h0;
        end else begin
            on_backup     <= s_trip && s_hys;
            supply_low_oe <= s_trip;
            bat_warn1     <= s_b85 || s_b75;
            bat_warn2     <= s_b75;
            serial_active <= !(s_trip && s_hys) || serial_on_backup_en;
            trip_level    <= (trip_sel < `RTCE_TRIP_LEVELS) ? trip_sel
                                                            : `RTCE_TRIP_LEVELS - 3'h1;
        end
    end

    // Timebase: line edges while present, crystal edges otherwise.
    logic        line_d, osc_d;
    logic [15:0] tb_cnt;
    logic [14:0] osc_div;
    logic        sec_tick;
    wire         line_rise = s_line && !line_d;
    wire         osc_rise  = s_osc && !osc_d;
    wire  [15:0] tb_top    = !s_lpr ? `RTCE_OSC_PER_SEC :
                             line_is_60hz ? `RTCE_LINE60_PER_SEC : `RTCE_LINE50_PER_SEC;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            line_d   <= 1'b0;
            osc_d    <= 1'b0;
            tb_cnt   <= 16'h0000;
            osc_div  <= 15'h0000;
            sec_tick <= 1'b0;
            use_line <= 1'b0;
        end else begin
            line_d   <= s_line;
            osc_d    <= s_osc;
            use_line <= s_lpr;
            sec_tick <= 1'b0;
            if (osc_rise)
                osc_div <= osc_div + 15'h0001;
            if (s_lpr ? line_rise : osc_rise) begin
                if (tb_cnt >= tb_top - 16'h0001) begin
                    tb_cnt   <= 16'h0000;
                    sec_tick <= 1'b1;
                end else begin
                    tb_cnt <= tb_cnt + 16'h0001;
                end
            end
        end
    end

    // Days in month for years 2000 to 2099, where every fourth year is a leap year.
    function automatic logic [4:0] days_in(input logic [3:0] mo, input logic [6:0] yr);
        unique case (mo)
            4'h2:                      days_in = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb:   days_in = 5'h1e;
            default:                   days_in = 5'h1f;
        endcase
    endfunction

    // Calendar with daylight saving correction at the configured dates.
    logic [5:0] t_sec, t_min;
    logic [4:0] t_hour, t_date;
    logic [3:0] t_mon;
    logic [6:0] t_year;
    logic       dst_back_done;
    logic       time_upd;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {t_sec, t_min, t_hour} <= 17'h00000;
            t_date        <= 5'h01;
            t_mon         <= 4'h1;
            t_year        <= 7'h00;
            dst_back_done <= 1'b0;
            time_upd      <= 1'b0;
        end else begin
            time_upd <= sec_tick;
            if (time_load) begin
                {t_year, t_mon, t_date, t_hour, t_min, t_sec} <= time_load_val;
                dst_back_done <= 1'b0;
            end else if (sec_tick) begin
                t_sec <= t_sec + 6'h01;
                if (t_sec == 6'h3b) begin
                    t_sec <= 6'h00;
                    t_min <= t_min + 6'h01;
                    if (t_min == 6'h3b) begin
                        t_min  <= 6'h00;
                        t_hour <= t_hour + 5'h01;
                        if (dst_en && t_mon == dst_fwd_month && t_date == dst_fwd_date
                            && t_hour + 5'h01 == `RTCE_DST_HOUR)
                            t_hour <= `RTCE_DST_HOUR + 5'h01;
                        if (dst_en && !dst_back_done && t_mon == dst_bwd_month
                            && t_date == dst_bwd_date && t_hour + 5'h01 == `RTCE_DST_HOUR) begin
                            t_hour        <= `RTCE_DST_HOUR - 5'h01;
                            dst_back_done <= 1'b1;
                        end
                        if (t_hour == 5'h17) begin
                            t_hour        <= 5'h00;
                            dst_back_done <= 1'b0;
                            t_date        <= t_date + 5'h01;
                            if (t_date == days_in(t_mon, t_year)) begin
                                t_date <= 5'h01;
                                t_mon  <= t_mon + 4'h1;
                                if (t_mon == 4'hc) begin
                                    t_mon  <= 4'h1;
                                    t_year <= t_year + 7'h01;
                                end
                            end
                        end
                    end
                end
            end
        end
    end
    wire [W-1:0] now = {t_year, t_mon, t_date, t_hour, t_min, t_sec};
    always_ff @(posedge core_clk) time_now <= now;

    // Alarms; masked field compare, blocked on backup since the alarm is unavailable there.
    localparam logic [W-1:0] FMASK [6] = '{33'h00000003f, 33'h000000fc0, 33'h00001f000,
                                           33'h0003e0000, 33'h003c00000, 33'h1fc000000};
    logic [1:0]  hit;
    logic [63:0] pulse_cnt;
    genvar a;
    generate
        for (a = 0; a < 2; a++) begin : g_alarm
            logic [W-1:0] cmp_mask;
            always_comb begin
                cmp_mask = '0;
                for (int f = 0; f < 6; f++)
                    if (alarm_field_en[a*6+f])
                        cmp_mask = cmp_mask | FMASK[f];
            end
            assign hit[a] = time_upd && alarm_en[a] && !on_backup && (cmp_mask != '0)
                            && (((now ^ alarm_val[a*W +: W]) & cmp_mask) == '0);
            always_ff @(posedge core_clk) begin
                if (sys_rst)
                    alarm_status[a] <= 1'b0;
                else if (hit[a])
                    alarm_status[a] <= 1'b1;
                else if (alarm_clr[a])
                    alarm_status[a] <= 1'b0;
            end
        end
    endgenerate

    // Interrupt: single mode holds until cleared, repeat mode gives a fixed pulse per match.
    wire repeat_hit = |(hit & alarm_irq_en & alarm_repeat);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pulse_cnt <= 64'h0;
            irq_oe    <= 1'b0;
        end else begin
            if (repeat_hit)
                pulse_cnt <= 64'(IRQ_PULSE_CYC);
            else if (pulse_cnt != 64'h0)
                pulse_cnt <= pulse_cnt - 64'h1;
            irq_oe <= repeat_hit || (pulse_cnt > 64'h1)
                      || |(alarm_status & alarm_irq_en & ~alarm_repeat);
        end
    end

    // Event detection and time stamps; link clear arrives as a toggle.
    logic                 ev_d;
    logic [1:0]           ts_ptr;
    logic [W-1:0]         ts_first;
    logic [W-1:0]         ts_mem [TS_DEPTH];
    logic [2:0]           clr_sync;
    logic                 clr_tgl;
    wire ev_enabled = event_det_en && (!on_backup || event_on_backup_en);
    wire ev_seen    = ev_enabled && s_evt;
    wire ev_trig    = ev_seen && !ev_d;
    wire ev_clr     = clr_sync[2] ^ clr_sync[1];
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ev_d            <= 1'b0;
            event_flag      <= 1'b0;
            event_detect_oe <= 1'b0;
            clr_sync        <= 3'h0;
        end else begin
            clr_sync <= {clr_sync[1:0], clr_tgl};
            ev_d     <= ev_seen;
            if (ev_seen)
                event_flag <= 1'b1;
            else if (ev_clr)
                event_flag <= 1'b0;
            event_detect_oe <= ev_seen || (event_flag && !ev_clr);
        end
    end

    // Stamp store: first is kept until cleared, and every stamp, first included, rolls over three slots.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            first_ts_valid <= 1'b0;
            ts_first       <= '0;
            ts_ptr         <= 2'h0;
        end else if (ev_trig) begin
            if (!first_ts_valid || ts_first_clr) begin      // A clear beside an event keeps the new one.
                ts_first       <= now;
                first_ts_valid <= 1'b1;
            end
            ts_ptr <= (ts_ptr == 2'(TS_DEPTH - 1)) ? 2'h0 : ts_ptr + 2'h1;
        end else if (ts_first_clr) begin
            first_ts_valid <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (ev_trig)
            ts_mem[ts_ptr] <= now;
    end

    // Indexed read: index 0 is the first stamp, 1 the latest, 3 the oldest of three.
    logic [2:0]   rq_sync;
    logic         rq_tgl, ack_tgl;
    logic [1:0]   rd_idx;
    logic [W-1:0] rd_word;
    // Summed in three bits, since two bits would wrap before the slot count is taken off.
    wire [2:0] age_sum = 3'(ts_ptr) + 3'(TS_DEPTH) - 3'(rd_idx);
    wire [1:0] age     = (age_sum >= 3'(TS_DEPTH)) ? 2'(age_sum - 3'(TS_DEPTH)) : age_sum[1:0];
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rq_sync <= 3'h0;
            ack_tgl <= 1'b0;
            rd_word <= '0;
        end else begin
            rq_sync <= {rq_sync[1:0], rq_tgl};
            if (rq_sync[2] ^ rq_sync[1]) begin
                rd_word <= (rd_idx == 2'h0) ? ts_first : ts_mem[age];
                ack_tgl <= !ack_tgl;
            end
        end
    end

    // Frequency output from crystal edge divider; crystal amplifier modelled as an inverter.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            freq_out <= 1'b0;
            osc_out  <= 1'b0;
        end else begin
            osc_out <= !s_osc;
            unique case (rtce_pkg::rtce_freq_type'(freq_sel))
                rtce_pkg::rtce_fq_off:   freq_out <= 1'b0;
                rtce_pkg::rtce_fq_1hz:   freq_out <= osc_div[`RTCE_FQ_1HZ_BIT];
                rtce_pkg::rtce_fq_2hz:   freq_out <= osc_div[`RTCE_FQ_2HZ_BIT];
                rtce_pkg::rtce_fq_4hz:   freq_out <= osc_div[`RTCE_FQ_4HZ_BIT];
                rtce_pkg::rtce_fq_8hz:   freq_out <= osc_div[`RTCE_FQ_8HZ_BIT];
                rtce_pkg::rtce_fq_64hz:  freq_out <= osc_div[`RTCE_FQ_64HZ_BIT];
                rtce_pkg::rtce_fq_1khz:  freq_out <= osc_div[`RTCE_FQ_1KHZ_BIT];
                rtce_pkg::rtce_fq_32khz: freq_out <= s_osc;
            endcase
        end
    end

    // Link domain: reset and serial-active level are brought over by two flops each.
    logic [1:0] lk_rst_s, lk_act_s;
    logic [2:0] ack_sync;
    rtce_pkg::rtce_link_state_type lk_state;
    always_ff @(posedge link_clk) begin
        lk_rst_s <= {lk_rst_s[0], sys_rst};
        lk_act_s <= {lk_act_s[0], serial_active};
    end
    // The index is held stable from the request toggle until the answer returns.
    always_ff @(posedge link_clk) begin
        if (lk_rst_s[1]) begin
            lk_state    <= rtce_pkg::rtce_lk_idle;
            rq_tgl      <= 1'b0;
            clr_tgl     <= 1'b0;
            rd_idx      <= 2'h0;
            ack_sync    <= 3'h0;
            ts_rd_valid <= 1'b0;
            ts_rd_data  <= '0;
        end else begin
            ack_sync    <= {ack_sync[1:0], ack_tgl};
            ts_rd_valid <= 1'b0;
            if (event_clr_req && lk_act_s[1])
                clr_tgl <= !clr_tgl;
            unique case (lk_state)
                rtce_pkg::rtce_lk_idle: begin
                    if (ts_rd_req && lk_act_s[1]) begin
                        rd_idx   <= ts_rd_index;
                        rq_tgl   <= !rq_tgl;
                        lk_state <= rtce_pkg::rtce_lk_wait;
                    end
                end
                rtce_pkg::rtce_lk_wait: begin
                    if (ack_sync[2] ^ ack_sync[1]) begin
                        ts_rd_data  <= rd_word;
                        ts_rd_valid <= 1'b1;
                        lk_state    <= rtce_pkg::rtce_lk_idle;
                    end
                end
            endcase
        end
    end
endmodule // rtce_ctrl
`default_nettype wire

// ### sim/rtce_ctrl_properties.sv
// Concurrent checks on the ports of the clock control block.
`timescale 1ns/1ns
`default_nettype none
module rtce_ctrl_properties #(parameter longint IRQ_PULSE_CYC = 64'h14) (
    // Clock, reset and pins.
    input wire logic       core_clk, sys_rst, main_below_trip, main_below_backup_hys, event_in,
    // Configuration.
    input wire logic       serial_on_backup_en, event_det_en,
    input wire logic [2:0] trip_sel, freq_sel,
    input wire logic [1:0] alarm_repeat, alarm_irq_en, alarm_status,
    // Outputs.
    input wire logic       event_flag, on_backup, serial_active, irq_oe, supply_low_oe,
    input wire logic       event_detect_oe, freq_out,
    input wire logic [2:0] trip_level
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] hi_cnt;
    // Pulse length is counted here, as the repeat limit is too long for a repetition.
    always_ff @(posedge core_clk) begin
        hi_cnt <= (sys_rst || !irq_oe) ? 32'h0 : hi_cnt + 32'h1;
    end
    property p_backup; $stable({main_below_trip, main_below_backup_hys})[*4]
        |-> on_backup == (main_below_trip && main_below_backup_hys); endproperty
    a_backup: assert property (p_backup) else $error("backup switch wrong");
    property p_low; $stable(main_below_trip)[*4] |-> supply_low_oe == main_below_trip; endproperty
    a_low: assert property (p_low) else $error("supply low pin wrong");
    property p_trip; $stable(trip_sel)[*3]
        |-> trip_level == ((trip_sel > 3'h5) ? 3'h5 : trip_sel); endproperty
    a_trip: assert property (p_trip) else $error("trip level wrong");
    property p_serial; $stable({main_below_trip, main_below_backup_hys, serial_on_backup_en})[*4]
        ##0 on_backup |-> serial_active == serial_on_backup_en; endproperty
    a_serial: assert property (p_serial) else $error("serial gate wrong");
    property p_freq; (freq_sel == 3'h0)[*3] |-> !freq_out; endproperty
    a_freq: assert property (p_freq) else $error("frequency pin not off");
    property p_ev_set; (event_det_en && !on_backup && event_in)[*4]
        |-> event_flag && event_detect_oe; endproperty
    a_ev_set: assert property (p_ev_set) else $error("event not flagged");
    property p_ev_gate; (!event_det_en)[*3] |-> !$rose(event_flag); endproperty
    a_ev_gate: assert property (p_ev_gate) else $error("gated event seen");
    property p_irq_len; alarm_repeat[0] && alarm_irq_en == 2'h1 && $fell(irq_oe)
        |-> hi_cnt == IRQ_PULSE_CYC; endproperty
    a_irq_len: assert property (p_irq_len) else $error("repeat pulse length wrong");
    property p_irq_stat; $rose(irq_oe) |-> (alarm_status & alarm_irq_en) != 2'h0; endproperty
    a_irq_stat: assert property (p_irq_stat) else $error("interrupt without status");
    c_irq: cover property ($rose(irq_oe));
    c_event: cover property ($rose(event_flag));
    c_backup: cover property ($rose(on_backup));
endmodule // rtce_ctrl_properties
bind rtce_ctrl rtce_ctrl_properties #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) i_props (.*);
`default_nettype wire

// ### sim/rtce_host_model.sv
// Host model on the link clock: stamp reads and event flag clears.
`timescale 1ns/1ns
`default_nettype none
module rtce_host_model (
    // Link clock and answers.
    input  wire logic        link_clk, ts_rd_valid,
    input  wire logic [32:0] ts_rd_data,
    // Requests.
    output var logic         ts_rd_req = 1'b0, event_clr_req = 1'b0,
    output var logic [1:0]   ts_rd_index = 2'h0
);
    // Request and index stand until valid shows; dropping them then keeps a second read out.
    task automatic read_stamp(input logic [1:0] idx, output logic [32:0] data);
        int n;
        data = 'x;
        n = 0;
        @(posedge link_clk);
        #2 ts_rd_req = 1'b1;
        ts_rd_index = idx;
        do begin
            @(posedge link_clk);
            #2 n++;
        end while (ts_rd_valid !== 1'b1 && n < 60);
        if (ts_rd_valid === 1'b1) data = ts_rd_data;
        ts_rd_req = 1'b0;
        ts_rd_index = ~idx;
        repeat (4) @(posedge link_clk);
    endtask
    // A clear is one link cycle long.
    task automatic clear_event();
        @(posedge link_clk);
        #2 event_clr_req = 1'b1;
        @(posedge link_clk);
        #2 event_clr_req = 1'b0;
    endtask
endmodule // rtce_host_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the clock control block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    // Stimulus.
    logic core_clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, main_below_trip = 1'b0;
    logic main_below_backup_hys = 1'b0, bat_below_85 = 1'b0, bat_below_75 = 1'b0;
    logic line_in = 1'b0, line_present = 1'b1, line_is_60hz = 1'b0, osc_in = 1'b0;
    logic event_in = 1'b0, serial_on_backup_en = 1'b0, event_det_en = 1'b0, dst_en = 1'b0;
    logic event_on_backup_en = 1'b0, time_load = 1'b0, ts_first_clr = 1'b0;
    logic [2:0]  trip_sel = 3'h0, freq_sel = 3'h0;
    logic [3:0]  dst_fwd_month = 4'h3, dst_bwd_month = 4'ha;
    logic [4:0]  dst_fwd_date = 5'h1b, dst_bwd_date = 5'h1b;
    logic [1:0]  alarm_en = 2'h0, alarm_irq_en = 2'h0, alarm_repeat = 2'h0, alarm_clr = 2'h0;
    logic [11:0] alarm_field_en = 12'h0;
    logic [65:0] alarm_val = 66'h0;
    logic [32:0] time_load_val = 33'h0;
    // Outputs and host link.
    logic        ts_rd_req, event_clr_req, ts_rd_valid, event_flag, first_ts_valid, bat_warn1;
    logic        bat_warn2, on_backup, serial_active, use_line, irq_oe, supply_low_oe, osc_out;
    logic        event_detect_oe, freq_out;
    logic [1:0]  ts_rd_index, alarm_status;
    logic [2:0]  trip_level;
    logic [32:0] ts_rd_data, time_now, stamp;
    // Rows: battery pins, warnings, trip select, trip, hys, serial enable, level, outputs.
    logic [15:0] rows [5] = '{16'h0001, 16'h0aa9, 16'ha513, 16'hfdae, 16'hffef};
    int          failures = 0, checks = 0, line_run = 0, n;
    rtce_ctrl #(.IRQ_PULSE_CYC(64'h14), .TS_DEPTH(3)) i_dut (.*);
    rtce_host_model i_host (.*);
    // Core clock, an unrelated link clock, a fast line input and the crystal.
    always #20 core_clk = ~core_clk;
    initial begin #7; forever #80 link_clk = ~link_clk; end
    always #160 if (line_run != 0) line_in = ~line_in;
    always #15259 osc_in = ~osc_in;
    task automatic tick(input int c); repeat (c) @(posedge core_clk); #2; endtask
    task automatic load(input logic [32:0] v);
        time_load_val = v;
        time_load = 1'b1;
        tick(1);
        time_load = 1'b0;
        tick(2);
    endtask
    task automatic wrap_up();
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // A hang costs far more than the roughly 1700 cycles the tests need.
    initial begin #3000000; failures++; wrap_up(); end
    initial begin
        tick(6);
        sys_rst = 1'b0;
        `CHK({irq_oe, supply_low_oe, event_detect_oe, event_flag, alarm_status, serial_active}, 7'h01)
        `CHK(time_now, 33'h000420000)
        $display("Test reset done");
        foreach (rows[i]) begin
            {bat_below_85, bat_below_75} = rows[i][15:14];
            {trip_sel, main_below_trip, main_below_backup_hys, serial_on_backup_en} = rows[i][11:6];
            tick(5);
            `CHK({bat_warn1, bat_warn2}, rows[i][13:12])
            `CHK(trip_level, rows[i][5:3])
            `CHK({on_backup, supply_low_oe, serial_active}, rows[i][2:0])
        end
        {bat_below_85, bat_below_75, main_below_trip, main_below_backup_hys} = 4'h0;
        tick(5);
        $display("Test power done");
        event_det_en = 1'b1;
        load(33'h060dea51e);
        event_in = 1'b1;
        tick(4);
        `CHK({event_flag, event_detect_oe}, 2'h3)
        event_in = 1'b0;
        i_host.clear_event();
        tick(6);
        `CHK(event_flag, 1'b0)
        load(33'h060dea52d);
        event_in = 1'b1;
        tick(4);
        event_in = 1'b0;
        i_host.clear_event();
        tick(6);
        event_det_en = 1'b0;
        event_in = 1'b1;
        tick(5);
        `CHK(event_flag, 1'b0)
        event_in = 1'b0;
        i_host.read_stamp(2'h0, stamp);
        `CHK(stamp, 33'h060dea51e)
        i_host.read_stamp(2'h1, stamp);
        `CHK(stamp, 33'h060dea52d)
        $display("Test events done");
        load(33'h060dea500);
        alarm_val = {33'h0, 33'h060dea502};
        alarm_field_en = 12'h001;
        {alarm_en, alarm_irq_en, alarm_repeat} = 6'h15;
        {line_is_60hz, freq_sel} = 4'hf;
        line_run = 1;
        n = 0;
        while (irq_oe !== 1'b1 && n < 3000) begin tick(1); n++; end
        `CHK({use_line, alarm_status, time_now[5:0]}, 9'h142)
        tick(25);
        `CHK({irq_oe, alarm_status}, 3'h1)
        alarm_clr = 2'h1;
        tick(1);
        alarm_clr = 2'h0;
        tick(1);
        `CHK(alarm_status, 2'h0)
        alarm_repeat = 2'h0;
        load(33'h060dea501);
        n = 0;
        while (irq_oe !== 1'b1 && n < 3000) begin tick(1); n++; end
        tick(25);
        `CHK({irq_oe, alarm_status}, 3'h5)
        alarm_clr = 2'h1;
        tick(1);
        alarm_clr = 2'h0;
        tick(2);
        `CHK({irq_oe, alarm_status}, 3'h0)
        {line_run, line_present} = 2'h0;
        tick(5);
        `CHK(use_line, 1'b0)
        `CHK({first_ts_valid, freq_out ^ osc_out}, 2'h3)
        ts_first_clr = 1'b1;
        tick(1);
        ts_first_clr = 1'b0;
        `CHK(first_ts_valid, 1'b0)
        $display("Test alarm done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
